// [rtl/insulation_fault_monitor.sv]
/*
 insulation fault monitor core: debounce, polarity, post-wake delay,
 nonvolatile fault store handshake, contactor close gating and wake
 power sequencing. assumes synchronous inputs and an outside store that
 acknowledges writes; the CAN framer samples can_fault_bit.
*/
`timescale 1ns/1ns
module insulation_fault_monitor
    import insulation_pkg::*;
#(
    parameter int unsigned DEBOUNCE_W = DBNC_W,
    parameter int unsigned TICK_DIV = TICK_CYCLES
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // pins
    input wire logic insulation_pin,
    input wire logic wake_input_state,
    input wire logic ignition_request_state,
    // configuration
    input wire polarity_t insulation_polarity_select,
    input wire logic [DEBOUNCE_W-1:0] low_level_debounce_time,
    input wire logic [DEBOUNCE_W-1:0] high_level_debounce_time,
    input wire logic [DELAY_W-1:0] post_wake_fault_delay,
    input wire inhibit_src_t contactor_inhibit_source,
    input wire logic stored_fault_clear,
    // nonvolatile store
    input wire logic nv_stored_at_wake,
    input wire logic nv_ack,
    output logic nv_write_r,
    output logic nv_value_r,
    // contactors and power
    input wire logic contactors_closed,
    output logic contactor_close_req_r,
    output logic contactor_inhibit_r,
    output logic shutdown_done_r,
    output power_state_t power_state_r,
    // status
    output fault_status_t status_r,
    output logic can_fault_bit_r
);
    if (TICK_DIV < 2 || DEBOUNCE_W < 2 || DEBOUNCE_W > 32) begin : bad_param_g
        $error("insulation_fault_monitor: bad parameters");
    end

    // millisecond tick
    logic [31:0] div_r;
    logic tick_r;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            div_r <= '0;
            tick_r <= 1'b0;
        end else begin
            tick_r <= div_r == 32'(TICK_DIV - 1);
            div_r <= (div_r == 32'(TICK_DIV - 1)) ? '0 : div_r + 32'h0000_0001;
        end
    end

    logic deb_level;
    level_debounce #(.W(DEBOUNCE_W)) u_deb (
        .ref_clk(ref_clk),
        .nrst(nrst),
        .tick(tick_r),
        .raw(insulation_pin),
        .low_time(low_level_debounce_time),
        .high_time(high_level_debounce_time),
        .level_r(deb_level)
    );

    // power sequencing
    power_state_t pwr_nxt;
    logic wake_d_r;
    wire wake_rise = wake_input_state && !wake_d_r;
    wire awake = power_state_r == PWR_AWAKE;
    logic pending_store_r;

    always_comb begin
        pwr_nxt = power_state_r;
        case (power_state_r)
            PWR_ASLEEP: if (wake_input_state) pwr_nxt = PWR_AWAKE;
            PWR_AWAKE: if (!wake_input_state) pwr_nxt = PWR_STORING;
            PWR_STORING: if (!pending_store_r && !nv_write_r)
                pwr_nxt = PWR_SHUTDOWN;
            PWR_SHUTDOWN: pwr_nxt = PWR_ASLEEP;
            default: pwr_nxt = PWR_ASLEEP;
        endcase
    end

    // post-wake delay in ticks (seconds times ms)
    logic [31:0] delay_ms_r;
    wire [31:0] delay_limit = 32'(post_wake_fault_delay) * 32'(MS_PER_S);
    wire delay_done = delay_ms_r >= delay_limit;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            delay_ms_r <= '0;
            wake_d_r <= 1'b0;
        end else begin
            wake_d_r <= wake_input_state;
            if (wake_rise)
                delay_ms_r <= '0;
            else if (awake && tick_r && !delay_done)
                delay_ms_r <= delay_ms_r + 32'h0000_0001;
        end
    end

    // fault decode
    wire enabled = insulation_polarity_select == POL_LOW_ON;
    wire live_nxt = enabled && awake && !deb_level;
    wire filt_nxt = live_nxt && delay_done;

    // stored fault, clear on any toggle of the clear setting
    logic clear_d_r;
    logic clear_armed_r;
    logic stored_r;
    logic stored_load_r;
    // the first sample after reset only arms the detector, so a clear
    // setting that is already high is not taken for a toggle
    wire clear_toggle = clear_armed_r &&
        (stored_fault_clear != clear_d_r);
    wire filt_rise = filt_nxt && !status_r.filtered_fault;
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            clear_d_r <= 1'b0;
            clear_armed_r <= 1'b0;
            stored_r <= 1'b0;
            stored_load_r <= 1'b0;
            pending_store_r <= 1'b0;
        end else begin
            clear_d_r <= stored_fault_clear;
            clear_armed_r <= 1'b1;
            // persisting value is reloaded from the store at each wake;
            // a clear at the wake edge must not be undone by that reload
            stored_load_r <= wake_rise && !clear_toggle;
            if (filt_rise || (filt_nxt && clear_toggle)) begin
                // a present filtered fault, new or standing, beats a simultaneous clear
                stored_r <= 1'b1;
                pending_store_r <= 1'b1;
            end else if (clear_toggle) begin
                stored_r <= 1'b0;
                pending_store_r <= 1'b1;
            end else if (stored_load_r) begin
                stored_r <= nv_stored_at_wake;
            end else if (!nv_write_r) begin
                pending_store_r <= 1'b0;
            end
        end
    end

    // store write: hold request until ack
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            nv_write_r <= 1'b0;
            nv_value_r <= 1'b0;
        end else if (nv_write_r) begin
            if (nv_ack) nv_write_r <= 1'b0;
        end else if (pending_store_r) begin
            nv_write_r <= 1'b1;
            nv_value_r <= stored_r;
        end
    end

    // contactor gating: only a closing from open is gated, closed contactors are not
    wire inhibit_nxt = enabled && (
        (contactor_inhibit_source == INH_LIVE && live_nxt) ||
        (contactor_inhibit_source == INH_FILTERED && filt_nxt));
    wire close_nxt = awake && ignition_request_state &&
        (contactors_closed || !inhibit_nxt);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            power_state_r <= PWR_ASLEEP;
            status_r <= '0;
            can_fault_bit_r <= 1'b0;
            contactor_inhibit_r <= 1'b0;
            contactor_close_req_r <= 1'b0;
            shutdown_done_r <= 1'b0;
        end else begin
            power_state_r <= pwr_nxt;
            status_r.pin_level <= insulation_pin;
            status_r.live_fault <= live_nxt;
            status_r.filtered_fault <= filt_nxt;
            status_r.stored_fault <= stored_r;
            can_fault_bit_r <= filt_nxt;
            contactor_inhibit_r <= inhibit_nxt && !contactors_closed;
            contactor_close_req_r <= close_nxt;
            shutdown_done_r <= power_state_r == PWR_SHUTDOWN;
        end
    end

    filt_needs_delay_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        status_r.filtered_fault |-> $past(delay_done) && status_r.live_fault)
        else $error("filtered fault without live fault or expired delay");
    disabled_quiet_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(!enabled) |-> !status_r.live_fault && !contactor_inhibit_r)
        else $error("outputs active while function disabled");
    can_mirror_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        can_fault_bit_r == status_r.filtered_fault)
        else $error("can bit differs from filtered fault");
    pin_report_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $past(nrst) |-> status_r.pin_level == $past(insulation_pin))
        else $error("pin level not reported");
    store_commit_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $rose(status_r.filtered_fault) |-> ##[1:3] nv_write_r && nv_value_r)
        else $error("filtered fault not committed");
    clear_erase_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (clear_toggle && !filt_nxt) |=> !stored_r ##[1:3] nv_write_r)
        else $error("clear toggle did not erase stored fault");
    timer_restart_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        wake_rise |=> delay_ms_r == 32'h0000_0000)
        else $error("delay timer not restarted at wake");
    no_open_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        (contactors_closed && awake && ignition_request_state)
        |=> contactor_close_req_r)
        else $error("closed contactors dropped by fault");
    ignore_mode_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        contactor_inhibit_source == INH_IGNORE |=> !contactor_inhibit_r)
        else $error("inhibit asserted in ignore mode");
    shutdown_order_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        shutdown_done_r |-> $past(!nv_write_r, 2))
        else $error("shutdown before store write finished");

    cov_fault_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        $rose(status_r.filtered_fault));
    cov_clear_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        $fell(status_r.stored_fault));
    cov_blocked_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        ignition_request_state && awake && contactor_inhibit_r);
    cov_shutdown_c: cover property (@(posedge ref_clk) disable iff (!nrst)
        shutdown_done_r);
endmodule // insulation_fault_monitor

// [pkg/insulation_pkg.sv]
/*
 insulation fault monitor package: timing constants, encodings and the
 status struct that the core reports on status_r.
 assumes a single 100 MHz clock; the millisecond tick is converted to cycles here.
*/
// Operation
// - report the insulation pin level: low reads 0, high reads 1.
// - polarity setting either disables the function or treats low as fault.
// - debounce the input with separate low and high persistence times.
// - live fault follows the polarity-adjusted debounced input, unfiltered.
// - hold off fault assertion for a set delay in seconds after each wake.
// - filtered fault is 1 when live fault is on after the delay.
// - filtered fault flag is sent in the CAN status report.
// - filtered fault commits to nonvolatile store; stored flag persists over wakes.
// - toggling the clear setting erases the stored fault.
// - contactor inhibit source: live fault, filtered fault, or ignore.
// - after contactors close, later faults never open them.
// - start on wake high; on wake low store data, then shut down.
// - ignition request triggers the first contactor close attempt.
package insulation_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 1;
    // cycles per millisecond tick
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned MS_PER_S = 1000;
    localparam logic [15:0] FAULT_DELAY_S_DEF = 16'h0014;
    localparam int unsigned DBNC_W = 16;
    localparam int unsigned DELAY_W = 16;

    typedef enum logic [0:0] {
        POL_LOW_OFF = 1'b0,
        POL_LOW_ON = 1'b1
    } polarity_t;

    typedef enum logic [1:0] {
        INH_LIVE = 2'b00,
        INH_FILTERED = 2'b01,
        INH_IGNORE = 2'b10
    } inhibit_src_t;

    typedef enum logic [1:0] {
        PWR_ASLEEP = 2'b00,
        PWR_AWAKE = 2'b01,
        PWR_STORING = 2'b10,
        PWR_SHUTDOWN = 2'b11
    } power_state_t;

    typedef struct packed {
        logic pin_level;
        logic live_fault;
        logic filtered_fault;
        logic stored_fault;
    } fault_status_t;
endpackage

// [rtl/level_debounce.sv]
/*
 level debouncer: accepts a new level only after it has persisted for the
 programmed number of ticks. tick is a one-cycle enable from a divider.
*/
`timescale 1ns/1ns
module level_debounce
    import insulation_pkg::*;
#(
    parameter int unsigned W = DBNC_W
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic nrst,
    // sample stream
    input wire logic tick,
    input wire logic raw,
    input wire logic [W-1:0] low_time,
    input wire logic [W-1:0] high_time,
    output logic level_r
);
    if (W < 2 || W > 32) begin : bad_width_g
        $error("level_debounce: W out of range");
    end

    logic [W-1:0] cnt_r;
    wire differs = raw != level_r;
    wire [W-1:0] limit = raw ? high_time : low_time;
    wire reached = differs && (cnt_r >= limit);

    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_r <= '0;
            level_r <= 1'b0;
        end else if (!differs) begin
            cnt_r <= '0;
        end else if (reached) begin
            level_r <= raw;
            cnt_r <= '0;
        end else if (tick) begin
            cnt_r <= cnt_r + W'(1);
        end
    end

    stable_change_a: assert property (@(posedge ref_clk) disable iff (!nrst)
        $changed(level_r) |-> level_r == $past(raw))
        else $error("debounced level took a value the input did not have");
endmodule // level_debounce

// [dv/imd_model.sv]
/*
 behavioural model of the insulation monitor's status output.
 assumes the bench commands faults and power; pin is pulled down.
*/
`timescale 1ns/1ns
module monitor_pin_model (
    // control
    input wire logic ref_clk,
    input wire logic powered,
    input wire logic fault_cmd,
    // status pin
    output logic status_pin
);
    logic level_r = 1'b1;
    // high means healthy, low means insulation fault
    always_ff @(posedge ref_clk) begin
        level_r <= !fault_cmd;
    end
    // the pull-down wins when the monitor is unpowered
    assign status_pin = powered ? level_r : 1'b0;
endmodule // monitor_pin_model

// [dv/tb.sv]
/*
 self-checking bench for the insulation fault monitor.
 assumes TICK_DIV of 4 and the bench acting as the nonvolatile store.
*/
`timescale 1ns/1ns
module tb;
    import insulation_pkg::*;
    logic ref_clk = 1'b0, nrst = 1'b0, wake = 1'b0, ign = 1'b0, clr = 1'b0;
    logic nv_mem = 1'b0, nv_ack = 1'b0, closed = 1'b0, fcmd = 1'b0;
    logic pwr = 1'b0, pin, nv_wr, nv_val, close_req, inhibit, sd_done, can;
    polarity_t pol = POL_LOW_ON;
    inhibit_src_t src = INH_IGNORE;
    logic [15:0] dly = 16'h0000;
    // unequal times so that a swapped threshold shows up
    logic [15:0] lo_t = 16'h0002, hi_t = 16'h0006;
    power_state_t pst;
    fault_status_t st;
    int fail_count = 0, check_count = 0, n;
    typedef struct {polarity_t p; logic f; logic [2:0] e;} row_t;
    row_t rows[4] = '{'{POL_LOW_ON, 1'b0, 3'b100}, '{POL_LOW_ON, 1'b1, 3'b011},
        '{POL_LOW_OFF, 1'b1, 3'b000}, '{POL_LOW_OFF, 1'b0, 3'b100}};
    inhibit_src_t srcs[3] = '{INH_LIVE, INH_FILTERED, INH_IGNORE};
    always #5 ref_clk = ~ref_clk;
    monitor_pin_model monitor_pin_model_i (.ref_clk(ref_clk), .powered(pwr),
        .fault_cmd(fcmd), .status_pin(pin));
    insulation_fault_monitor #(.TICK_DIV(4)) insulation_fault_monitor_i (
        .ref_clk(ref_clk), .nrst(nrst), .insulation_pin(pin),
        .wake_input_state(wake), .ignition_request_state(ign),
        .insulation_polarity_select(pol),
        .low_level_debounce_time(lo_t),
        .high_level_debounce_time(hi_t), .post_wake_fault_delay(dly),
        .contactor_inhibit_source(src), .stored_fault_clear(clr),
        .nv_stored_at_wake(nv_mem), .nv_ack(nv_ack), .nv_write_r(nv_wr),
        .nv_value_r(nv_val), .contactors_closed(closed),
        .contactor_close_req_r(close_req), .contactor_inhibit_r(inhibit),
        .shutdown_done_r(sd_done), .power_state_r(pst), .status_r(st),
        .can_fault_bit_r(can));
    // store acknowledges one cycle after a write request and keeps the value
    always @(posedge ref_clk) begin
        nv_ack <= nv_wr && !nv_ack;
        if (nv_wr && !nv_ack) nv_mem <= nv_val;
    end
    task automatic chk(input string nm, input logic e, input logic g);
        check_count++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] %s expected %b seen %b", nm, e, g);
        end
    endtask
    task automatic chk_pw(input power_state_t e);
        check_count++;
        if (pst !== e) begin
            fail_count++;
            $display("[FAIL] power_state expected %0d seen %0d", e, pst);
        end
    endtask
    task automatic settle(input int c);
        repeat (c) @(negedge ref_clk);
    endtask
    task automatic results();
        if (fail_count == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    initial begin
        settle(2);
        chk("status", 1'b1, st === 4'b0000);
        chk_pw(PWR_ASLEEP);
        chk("close_req", 1'b0, close_req);
        @(posedge ref_clk) nrst <= 1'b1;
        @(posedge ref_clk) wake <= 1'b1;
        pwr <= 1'b1;
        settle(3);
        chk_pw(PWR_AWAKE);
        foreach (rows[i]) begin
            @(posedge ref_clk) pol <= rows[i].p;
            fcmd <= rows[i].f;
            settle(40);
            chk("pin_level", rows[i].e[2], st.pin_level);
            chk("live", rows[i].e[1], st.live_fault);
            chk("filtered", rows[i].e[0], st.filtered_fault);
            chk("can_bit", rows[i].e[0], can);
        end
        chk("stored", 1'b1, st.stored_fault);
        chk("nv_mem", 1'b1, nv_mem);
        // sleep, then wake with a one second hold-off and a fault present
        @(posedge ref_clk) wake <= 1'b0;
        n = 0;
        while (sd_done !== 1'b1 && n < 300) begin
            settle(1);
            n++;
        end
        chk("shutdown_done", 1'b1, sd_done);
        chk_pw(PWR_ASLEEP);
        if (n >= 300) results();
        @(posedge ref_clk) dly <= 16'h0001;
        pol <= POL_LOW_ON;
        fcmd <= 1'b1;
        wake <= 1'b1;
        settle(40);
        chk("live", 1'b1, st.live_fault);
        chk("held_off", 1'b0, st.filtered_fault);
        chk("stored", 1'b1, st.stored_fault);
        n = 40;
        while (st.filtered_fault !== 1'b1 && n < 4600) begin
            settle(1);
            n++;
        end
        // 1000 ticks of 4 cycles from the wake rise
        chk("delay_len", 1'b1, n > 3950 && n < 4100);
        if (n >= 4600) results();
        // clear while faulted: the fault wins
        @(posedge ref_clk) clr <= ~clr;
        settle(20);
        chk("stored", 1'b1, st.stored_fault);
        foreach (srcs[i]) begin
            @(posedge ref_clk) src <= srcs[i];
            ign <= 1'b1;
            settle(10);
            chk("inhibit", srcs[i] != INH_IGNORE, inhibit);
            chk("close_req", srcs[i] == INH_IGNORE, close_req);
        end
        @(posedge ref_clk) fcmd <= 1'b0;
        src <= INH_LIVE;
        // high must persist six ticks: the fault still stands after 14 cycles
        settle(14);
        chk("high_hold", 1'b1, st.live_fault);
        settle(26);
        chk("high_done", 1'b0, st.live_fault);
        @(posedge ref_clk) clr <= ~clr;
        settle(20);
        chk("stored", 1'b0, st.stored_fault);
        chk("nv_mem", 1'b0, nv_mem);
        chk("close_req", 1'b1, close_req);
        @(posedge ref_clk) closed <= 1'b1;
        settle(3);
        @(posedge ref_clk) fcmd <= 1'b1;
        settle(40);
        chk("live", 1'b1, st.live_fault);
        chk("close_req", 1'b1, close_req);
        // reset in mid-run: outputs clear, stored flag comes back from store
        @(posedge ref_clk) nrst <= 1'b0;
        settle(2);
        chk("status", 1'b1, st === 4'b0000);
        chk_pw(PWR_ASLEEP);
        chk("close_req", 1'b0, close_req);
        @(posedge ref_clk) nrst <= 1'b1;
        settle(5);
        chk_pw(PWR_AWAKE);
        chk("stored_reload", 1'b1, st.stored_fault);
        chk("held_off", 1'b0, st.filtered_fault);
        chk("close_req", 1'b1, close_req);
        results();
    end
endmodule // tb
